// File: dv/ddw_checker.sv
// Link checker for the three-wire serial interface
`timescale 1ns/1ps
module ddw_checker
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame_select_n
);
  logic [5:0]  falls_q;
  logic [15:0] word_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------
  // Helper logic
  // ----------
  // Counts falls per frame so partial words are caught at frame end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      falls_q <= 6'h00;
    else if (frame_select_n)
      falls_q <= 6'h00;
    else if ($fell(sclk))
      falls_q <= falls_q + 6'h01;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      word_q <= 16'h0000;
    else if (!frame_select_n && $fell(sclk))
      word_q <= {word_q[14:0], sdata};

  // ----------
  // Assertions
  // ----------
  sequence s_open;
    $fell(frame_select_n);
  endsequence

  sequence s_close;
    $rose(frame_select_n);
  endsequence

  AST_SCLK_IDLE_HIGH: assert property (s_open |-> sclk)
    else $error("sclk low when frame opened");
  AST_FALL_IN_FRAME: assert property ($fell(sclk) |-> !frame_select_n)
    else $error("sclk fell outside a frame");
  AST_DATA_STEADY: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("sdata moved at sclk fall");
  AST_FALL_SPACING: assert property ($fell(sclk) |=> !$fell(sclk) [*8])
    else $error("sclk falls too close");
  AST_FIRST_FALL: assert property (s_open |-> ##[1:30] $fell(sclk))
    else $error("no sclk fall after frame opened");
  AST_FRAME_BOUND: assert property (s_open |-> ##[1:250] s_close)
    else $error("frame never closed");
  AST_WHOLE_WORD: assert property (s_close |-> falls_q == 6'h10)
    else $error("frame closed without sixteen falls");
  AST_RESERVED_ZERO: assert property ($rose(frame_select_n) && word_q[15:14] == 2'h0
    |-> !word_q[2])
    else $error("control word with reserved bit set");
endmodule

// File: dv/tb_dds_control_word_decoder.sv
// Bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module tb_dds_control_word_decoder
  import ddw_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mclk_en;
  logic [15:0] ctl;
  logic [27:0] fa;
  logic [27:0] fb;
  logic [11:0] aa;
  logic [11:0] ab;
  logic [27:0] acc;
  logic [11:0] pout;
  logic        pd;
  logic [31:0] rd;
  logic        err;
  logic [27:0] a1;
  logic        strobe;
  int          lat;
  int          num_errors;
  int          n_compared;

  ddw_link_if link ();
  ddw_host ddw_host_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.host)
  );
  ddw_device ddw_device_i
  (
    .pclk(pclk), .presetn(presetn), .link(link.device), .mclk_en(mclk_en),
    .operating_control(ctl), .freq_word_a(fa), .freq_word_b(fb), .angle_offset_a(aa),
    .angle_offset_b(ab), .phase_acc(acc), .phase_out(pout), .converter_powerdown(pd),
    .word_strobe(strobe)
  );
  ddw_checker ddw_checker_i
  (
    .pclk(pclk), .presetn(presetn), .sclk(link.sclk), .sdata(link.sdata),
    .frame_select_n(link.frame_select_n)
  );

  // ----------
  // Clocks
  // ----------
  initial
  begin
    pclk = 1'b0;
    forever
      #12.5 pclk = ~pclk;
  end

  // Tick on every second cycle, so one accumulator step per two cycles
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      mclk_en <= 1'b0;
    else
      mclk_en <= ~mclk_en;

  // Master clock ticks since the last load strobe
  always @(posedge pclk)
    if (strobe === 1'b1)
      lat <= 0;
    else if (mclk_en === 1'b1)
      lat <= lat + 1;

  // ----------
  // Shared tasks
  // ----------
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    end_of_test();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 500);
    if (pready !== 1'b1)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls busy so the next word never stalls the bus behind a frame
  task automatic send(input logic [15:0] w);
    int n;
    apb(1'b1, OFS_TX, {16'h0000, w});
    rd = 32'h1;
    for (n = 0; n < 100 && rd[0] !== 1'b0; n++)
      apb(1'b0, OFS_STATUS, 32'h0);
    if (rd[0] !== 1'b0)
      hang();
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_split();
    send(16'h0000);
    send(16'h5234);
    chk("freq_a", 32'h0001234, {4'h0, fa});
    send(16'h1000);
    send(16'h4abc);
    chk("freq_a", 32'h2af1234, {4'h0, fa});
    chk("control", 32'h1000, {16'h0, ctl});
  endtask

  task automatic t_full();
    send(16'h3000);
    send(16'h8555);
    chk("freq_b", 32'h0, {4'h0, fb});
    send(16'haaaa);
    chk("freq_b", 32'haaa8555, {4'h0, fb});
  endtask

  task automatic t_angle();
    send(16'he123);
    send(16'hc456);
    chk("angle_b", 32'h123, {20'h0, ab});
    chk("angle_a", 32'h456, {20'h0, aa});
  endtask

  task automatic t_run();
    send(16'h0100);
    chk("acc", 32'h0, {4'h0, acc});
    chk("phase_out", 32'h0, {20'h0, pout});
    send(16'h0800);
    @(posedge pclk);
    a1 = acc;
    repeat (2) @(posedge pclk);
    chk("step", 32'haaa8555, {4'h0, acc - a1});
    send(16'h0880);
    chk("control", 32'h0880, {16'h0, ctl});
    a1 = acc;
    repeat (9) @(posedge pclk);
    chk("acc held", {4'h0, a1}, {4'h0, acc});
    send(16'h0040);
    chk("powerdown", 32'h1, {31'h0, pd});
    send(16'h0000);
    chk("powerdown", 32'h0, {31'h0, pd});
  endtask

  // Zero increment and cleared accumulator, so only the offset reaches phase_out
  task automatic t_latency();
    int n;
    send(16'h1004);
    chk("control", 32'h1000, {16'h0, ctl});
    send(16'h4000);
    send(16'h0100);
    send(16'h4000);
    send(16'h0000);
    chk("freq_a", 32'h0, {4'h0, fa});
    repeat (20) @(posedge pclk);
    chk("phase_out", 32'h456, {20'h0, pout});
    send(16'hc789);
    for (n = 0; n < 100 && pout !== 12'h789; n++)
      @(posedge pclk);
    chk("phase_out", 32'h789, {20'h0, pout});
    // The tick that takes the new offset falls before the strobe is seen
    chk("latency", LATENCY_MIN - 1, lat);
  endtask

  task automatic t_bus();
    apb(1'b0, 8'h08, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("rdata", 32'h0, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h2, rd);
  endtask

  initial
  begin
    num_errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_split();
    t_full();
    t_angle();
    t_run();
    t_latency();
    t_bus();
    end_of_test();
  end
endmodule

// File: shared/ddw_link_if.sv
// Three-wire serial link between host and waveform device
`timescale 1ns/1ps
interface ddw_link_if;
  logic sclk;
  logic sdata;
  logic frame_select_n;

  modport host
  (
    output sclk,
    output sdata,
    output frame_select_n
  );

  modport device
  (
    input sclk,
    input sdata,
    input frame_select_n
  );
endinterface

// File: shared/ddw_pkg.sv
// Shared constants and types for the control word decoder link
package ddw_pkg;

  localparam int WORD_W    = 16;
  localparam int FREQ_W    = 28;
  localparam int HALF_W    = 14;
  localparam int ANGLE_W   = 12;
  localparam int BIT_CNT_W = 4;

  // Word tag and control field positions
  localparam int TAG_HI        = 15;
  localparam int TAG_LO        = 14;
  localparam int POS_FULL_WORD = 13;
  localparam int POS_HALF_SEL  = 12;
  localparam int POS_FREQ_SEL  = 11;
  localparam int POS_ANGLE_SEL = 10;
  localparam int POS_RESET     = 8;
  localparam int POS_CLK_HALT  = 7;
  localparam int POS_DAC_PD    = 6;
  localparam int POS_RESERVED  = 2;

  localparam logic [1:0] TAG_CONTROL = 2'h0;
  localparam logic [1:0] TAG_FREQ_A  = 2'h1;
  localparam logic [1:0] TAG_FREQ_B  = 2'h2;
  localparam logic [1:0] TAG_ANGLE   = 2'h3;
  localparam int         ANGLE_SEL_BIT = 13;

  localparam logic [15:0] CTRL_RESET_VAL = 16'h0000;

  // Output latency after a register load, in master clock cycles
  localparam int LATENCY_MIN = 7;
  localparam int LATENCY_MAX = 8;
  localparam logic [3:0] LATENCY_CYC = 4'h7;

  // Host serial clock divider: last divider count; a half period is SCLK_HALF plus one pclk cycles
  localparam logic [3:0] SCLK_HALF = 4'h4;
  localparam logic [3:0] BITS_LAST = 4'hf;

  // Host bus register offsets
  localparam logic [7:0] OFS_TX     = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  typedef enum logic [3:0]
  {
    HST_IDLE  = 4'h1,
    HST_SETUP = 4'h2,
    HST_SHIFT = 4'h4,
    HST_END   = 4'h8
  } ddw_host_state_type;

  function automatic logic [27:0] ddw_merge_half(input logic [27:0] cur,
                                                 input logic [13:0] half,
                                                 input logic        upper);
    ddw_merge_half = upper ? {half, cur[13:0]} : {cur[27:14], half};
  endfunction

endpackage

// File: verilog/ddw_device.sv
// Device end: serial word receiver, control decoder and frequency loader
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module ddw_device
  import ddw_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Serial link
  ddw_link_if.device              link,
  // Master clock enable (one pulse per master clock cycle)
  input  wire logic               mclk_en,
  // Observed state
  output logic [WORD_W-1:0]       operating_control,
  output logic [FREQ_W-1:0]       freq_word_a,
  output logic [FREQ_W-1:0]       freq_word_b,
  output logic [ANGLE_W-1:0]      angle_offset_a,
  output logic [ANGLE_W-1:0]      angle_offset_b,
  output logic [FREQ_W-1:0]       phase_acc,
  output logic [ANGLE_W-1:0]      phase_out,
  output logic                    converter_powerdown,
  output logic                    word_strobe
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sclk_s_q;
  logic [1:0] sdata_s_q;
  logic [1:0] fsn_s_q;
  logic       sclk_old_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_s_q   <= 2'h3;
      sdata_s_q  <= 2'h0;
      fsn_s_q    <= 2'h3;
      sclk_old_q <= 1'h1;
    end
    else
    begin
      sclk_s_q   <= {sclk_s_q[0], link.sclk};
      sdata_s_q  <= {sdata_s_q[0], link.sdata};
      fsn_s_q    <= {fsn_s_q[0], link.frame_select_n};
      sclk_old_q <= sclk_s_q[1];
    end
  end

  logic sclk_fall;
  assign sclk_fall = sclk_old_q & ~sclk_s_q[1];

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  logic [WORD_W-1:0]    shift_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic                 word_done_q;
  logic [WORD_W-1:0]    word_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q     <= 16'h0000;
      bit_cnt_q   <= 4'h0;
      word_done_q <= 1'h0;
      word_q      <= 16'h0000;
    end
    else
    begin
      word_done_q <= 1'h0;
      if (fsn_s_q[1])
        bit_cnt_q <= 4'h0;
      else if (sclk_fall)
      begin
        shift_q   <= {shift_q[WORD_W-2:0], sdata_s_q[1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == BITS_LAST)
        begin
          word_done_q <= 1'h1;
          word_q      <= {shift_q[WORD_W-2:0], sdata_s_q[1]};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Control register and frequency loading
  // ------------------------------------------------------------
  // Control takes effect on a master clock tick, the model of its falling-edge sample
  logic [WORD_W-1:0] ctrl_pend_q;
  logic              ctrl_pend_v_q;
  logic [HALF_W-1:0] low_half_q;
  logic              low_seen_q;
  logic [1:0]        low_tag_q;
  logic              load_pulse_q;

  logic [1:0]        tag;
  logic [HALF_W-1:0] dat;
  assign tag = word_q[TAG_HI:TAG_LO];
  assign dat = word_q[HALF_W-1:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operating_control <= CTRL_RESET_VAL;
      ctrl_pend_q       <= CTRL_RESET_VAL;
      ctrl_pend_v_q     <= 1'h0;
      freq_word_a       <= 28'h0000000;
      freq_word_b       <= 28'h0000000;
      angle_offset_a    <= 12'h000;
      angle_offset_b    <= 12'h000;
      low_half_q        <= 14'h0000;
      low_seen_q        <= 1'h0;
      low_tag_q         <= 2'h0;
      load_pulse_q      <= 1'h0;
    end
    else
    begin
      load_pulse_q <= 1'h0;
      if (ctrl_pend_v_q && mclk_en)
      begin
        operating_control <= ctrl_pend_q;
        ctrl_pend_v_q     <= 1'h0;
      end
      if (word_done_q)
      begin
        if (tag == TAG_CONTROL)
        begin
          ctrl_pend_q   <= word_q;
          ctrl_pend_v_q <= 1'h1;
          low_seen_q    <= 1'h0;
        end
        else if (tag == TAG_ANGLE)
        begin
          load_pulse_q <= 1'h1;
          if (word_q[ANGLE_SEL_BIT])
            angle_offset_b <= word_q[ANGLE_W-1:0];
          else
            angle_offset_a <= word_q[ANGLE_W-1:0];
        end
        else if (operating_control[POS_FULL_WORD])
        begin
          if (!low_seen_q)
          begin
            low_half_q <= dat;
            low_seen_q <= 1'h1;
            low_tag_q  <= tag;
          end
          else
          begin
            // Mismatched second address is taken as a new first half
            low_seen_q <= 1'h0;
            if (low_tag_q != tag)
            begin
              low_half_q <= dat;
              low_seen_q <= 1'h1;
              low_tag_q  <= tag;
            end
            else
            begin
              load_pulse_q <= 1'h1;
              if (tag == TAG_FREQ_B)
                freq_word_b <= {dat, low_half_q};
              else
                freq_word_a <= {dat, low_half_q};
            end
          end
        end
        else
        begin
          load_pulse_q <= 1'h1;
          low_seen_q   <= 1'h0;
          if (tag == TAG_FREQ_B)
            freq_word_b <= ddw_merge_half(freq_word_b, dat, operating_control[POS_HALF_SEL]);
          else
            freq_word_a <= ddw_merge_half(freq_word_a, dat, operating_control[POS_HALF_SEL]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Accumulator with output latency pipeline
  // ------------------------------------------------------------
  // Reserved bit two is not decoded, so a stray one is harmless.
  logic [FREQ_W-1:0]  incr;
  logic [ANGLE_W-1:0] offs;
  assign incr = operating_control[POS_FREQ_SEL] ? freq_word_b : freq_word_a;
  assign offs = operating_control[POS_ANGLE_SEL] ? angle_offset_b : angle_offset_a;

  // Seven stages behind the offset adder; a frequency load adds the accumulator tick
  logic [ANGLE_W-1:0] pipe_q [LATENCY_MIN];
  logic               in_reset;
  assign in_reset = operating_control[POS_RESET];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_acc <= 28'h0000000;
      for (int i = 0; i < LATENCY_MIN; i++)
        pipe_q[i] <= 12'h000;
    end
    else if (mclk_en && !operating_control[POS_CLK_HALT])
    begin
      if (in_reset)
      begin
        phase_acc <= 28'h0000000;
        for (int i = 0; i < LATENCY_MIN; i++)
          pipe_q[i] <= 12'h000;
      end
      else
      begin
        phase_acc <= phase_acc + incr;
        pipe_q[0] <= phase_acc[FREQ_W-1:FREQ_W-ANGLE_W] + offs;
        for (int i = 1; i < LATENCY_MIN; i++)
          pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_out           <= 12'h000;
      converter_powerdown <= 1'h0;
      word_strobe         <= 1'h0;
    end
    else
    begin
      phase_out           <= pipe_q[LATENCY_MIN-1];
      converter_powerdown <= operating_control[POS_DAC_PD];
      word_strobe         <= load_pulse_q;
    end
  end

endmodule

// File: verilog/ddw_host.sv
// Host end: APB-programmed serial word transmitter
`timescale 1ns/1ps
module ddw_host
  import ddw_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  ddw_link_if.host         link
);

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  ddw_host_state_type   state_q;
  logic [WORD_W-1:0]    tx_q;
  logic [3:0]           div_q;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic                 sent_q;
  logic                 wr_tx;

  // Write lands on the edge that completes the access, not one earlier
  assign wr_tx = psel && penable && pready && pwrite &&
                 (paddr == OFS_TX) && (state_q == HST_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q             <= HST_IDLE;
      tx_q                <= 16'h0000;
      div_q               <= 4'h0;
      cnt_q               <= 4'h0;
      sent_q              <= 1'h0;
      link.sclk           <= 1'h1;
      link.sdata          <= 1'h0;
      link.frame_select_n <= 1'h1;
    end
    else
    begin
      case (state_q)
        HST_IDLE:
        begin
          if (wr_tx)
          begin
            // Reserved bit forced to zero on control words.
            tx_q <= (pwdata[TAG_HI:TAG_LO] == TAG_CONTROL) ?
                    (pwdata[15:0] & ~(16'h0001 << POS_RESERVED)) : pwdata[15:0];
            link.frame_select_n <= 1'h0;
            div_q   <= 4'h0;
            sent_q  <= 1'h0;
            state_q <= HST_SETUP;
          end
        end
        HST_SETUP:
        begin
          div_q <= div_q + 4'h1;
          if (div_q == SCLK_HALF)
          begin
            link.sdata <= tx_q[WORD_W-1];
            tx_q       <= {tx_q[WORD_W-2:0], 1'h0};
            cnt_q      <= 4'h0;
            div_q      <= 4'h0;
            state_q    <= HST_SHIFT;
          end
        end
        HST_SHIFT:
        begin
          div_q <= div_q + 4'h1;
          if (div_q == SCLK_HALF)
          begin
            div_q     <= 4'h0;
            link.sclk <= ~link.sclk;
            if (!link.sclk)
            begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == BITS_LAST)
                state_q <= HST_END;
              else
              begin
                link.sdata <= tx_q[WORD_W-1];
                tx_q       <= {tx_q[WORD_W-2:0], 1'h0};
              end
            end
          end
        end
        HST_END:
        begin
          div_q <= div_q + 4'h1;
          if (div_q == SCLK_HALF)
          begin
            link.frame_select_n <= 1'h1;
            sent_q              <= 1'h1;
            state_q             <= HST_IDLE;
          end
        end
        default:
          state_q <= HST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  // Writes to TX while busy wait, giving back-pressure without a buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
    end
    else
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      if (psel && penable && !pready)
      begin
        if (!pwrite || paddr != OFS_TX || state_q == HST_IDLE)
        begin
          pready  <= 1'h1;
          pslverr <= (paddr != OFS_TX) && (paddr != OFS_STATUS);
          prdata  <= (paddr == OFS_STATUS) ?
                     {30'h00000000, sent_q, (state_q != HST_IDLE)} : 32'h00000000;
        end
      end
    end
  end

endmodule
